// File: rtl/pcaf_top.sv
// port c alternate function override logic
//
// Function
// - fuse programmed: bit 6 is a plain I/O bit, no pin reset.
// - fuse unprogrammed: bit 6 feeds reset circuitry, not usable as I/O.
// - bit 6 as reset: direction, latch and input sample read zero.
// - two-wire enable hands bit 5 to the interface as clock line.
// - two-wire enable hands bit 4 to the interface as data line.
// - two-wire input paths reject pulses shorter than 50 ns.
// - two-wire lines are open drain: value low, interface drives direction.
// - two-wire pull-up needs latch set and global disable clear; slew limited.
// - port bit n feeds pin-change source 8 plus n.
// - bits 0-5: converter disable kills input unless pin-change source armed.
// - bits 4-6 overrides only while their owning function is active.
// - global pull-up disable turns pull-ups off even for input with latch high, except bit 6 as reset input.
`timescale 1ns/1ps
module pcaf_top
  import pcaf_pkg::*;
#(
  parameter int unsigned SPIKE_CYCLES_P = SPIKE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // port register contents
  input wire logic [PORT_WIDTH-1:0] portc_direction,
  input wire logic [PORT_WIDTH-1:0] portc_output_latch,
  input wire logic global_pullup_disable,
  // configuration
  input wire logic reset_pin_disable_fuse,
  input wire logic two_wire_enable,
  input wire logic pin_change_group1_enable,
  input wire logic [PORT_WIDTH-1:0] pin_change_mask,
  input wire logic [NUM_CONV_CH-1:0] conv_digital_input_disable,
  // two-wire interface side
  input wire logic scl_out,
  input wire logic sda_out,
  output logic scl_in,
  output logic sda_in,
  // reset circuitry side
  output logic ext_reset_n,
  // pin-change logic side
  output logic [PCINT_BASE+PORT_WIDTH-1:PCINT_BASE] pin_change_source,
  // register read-back
  output logic [PORT_WIDTH-1:0] direction_read,
  output logic [PORT_WIDTH-1:0] output_latch_read,
  output logic [PORT_WIDTH-1:0] input_sample_read,
  // pads
  input wire logic [PORT_WIDTH-1:0] pad_in,
  output logic [PORT_WIDTH-1:0] pad_out,
  output logic [PORT_WIDTH-1:0] pad_oe,
  output logic [PORT_WIDTH-1:0] pad_pullup,
  output logic [PORT_WIDTH-1:0] pad_slew_limit,
  output logic [PORT_WIDTH-1:0] pad_input_enable
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [PORT_WIDTH-1:0] pin_sample;
  } pcaf_state_s;

  pcaf_state_s state_reg;
  pcaf_state_s state_next;

  // =====================================================================
  // helpers
  function automatic logic pcaf_pick(input logic ovr_en, input logic ovr_val, input logic normal);
    pcaf_pick = ovr_en ? ovr_val : normal;
  endfunction

  // =====================================================================
  // override terms
  logic reset_mode;
  logic [PORT_WIDTH-1:0] pc_armed;
  logic [PORT_WIDTH-1:0] pullup_override_enable;
  logic [PORT_WIDTH-1:0] pullup_override_value;
  logic [PORT_WIDTH-1:0] direction_override_enable;
  logic [PORT_WIDTH-1:0] direction_override_value;
  logic [PORT_WIDTH-1:0] out_value_override_enable;
  logic [PORT_WIDTH-1:0] out_value_override_value;
  logic [PORT_WIDTH-1:0] input_enable_override_enable;
  logic [PORT_WIDTH-1:0] input_enable_override_value;
  logic [PORT_WIDTH-1:0] dir_eff;
  logic [PORT_WIDTH-1:0] pullup_normal;

  // unprogrammed fuse leaves the pin on the reset circuitry
  assign reset_mode = ~reset_pin_disable_fuse;
  assign pc_armed = pin_change_mask & {PORT_WIDTH{pin_change_group1_enable}};

  always_comb begin
    // untouched bits keep plain port control
    pullup_override_enable = '0;
    pullup_override_value = '0;
    direction_override_enable = '0;
    direction_override_value = '0;
    out_value_override_enable = '0;
    out_value_override_value = '0;
    input_enable_override_enable = '0;
    input_enable_override_value = '0;

    // converter channels: a disabled buffer stays on only for an armed pin-change source
    for (int i = 0; i < NUM_CONV_CH; i++) begin
      input_enable_override_enable[i] = pc_armed[i] | conv_digital_input_disable[i];
      input_enable_override_value[i] = pc_armed[i];
    end

    // bit 6: reset input needs pull-up and input buffer, never drives
    input_enable_override_enable[BIT_RESET] = reset_mode | pc_armed[BIT_RESET];
    input_enable_override_value[BIT_RESET] = 1'b1;
    if (reset_mode) begin
      pullup_override_enable[BIT_RESET] = 1'b1;
      pullup_override_value[BIT_RESET] = 1'b1;
      direction_override_enable[BIT_RESET] = 1'b1;
      direction_override_value[BIT_RESET] = 1'b0;
    end

    // bit 7: pin-change only
    input_enable_override_enable[BIT_TOP] = pc_armed[BIT_TOP];
    input_enable_override_value[BIT_TOP] = 1'b1;

    // bits 4 and 5: open drain, the interface's out bit pulls the line low
    if (two_wire_enable) begin
      pullup_override_enable[BIT_SCL] = 1'b1;
      pullup_override_enable[BIT_SDA] = 1'b1;
      pullup_override_value[BIT_SCL] = portc_output_latch[BIT_SCL] & ~global_pullup_disable;
      pullup_override_value[BIT_SDA] = portc_output_latch[BIT_SDA] & ~global_pullup_disable;
      direction_override_enable[BIT_SCL] = 1'b1;
      direction_override_enable[BIT_SDA] = 1'b1;
      direction_override_value[BIT_SCL] = scl_out;
      direction_override_value[BIT_SDA] = sda_out;
      out_value_override_enable[BIT_SCL] = 1'b1;
      out_value_override_enable[BIT_SDA] = 1'b1;
      out_value_override_value[BIT_SCL] = 1'b0;
      out_value_override_value[BIT_SDA] = 1'b0;
    end
  end

  // =====================================================================
  // pad drive
  // input with latch high means pull-up, unless globally disabled
  assign pullup_normal = ~portc_direction & portc_output_latch & {PORT_WIDTH{~global_pullup_disable}};

  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      dir_eff[i] = pcaf_pick(direction_override_enable[i], direction_override_value[i], portc_direction[i]);
      pad_oe[i] = dir_eff[i];
      pad_out[i] = pcaf_pick(out_value_override_enable[i], out_value_override_value[i], portc_output_latch[i]);
      // a driven pad never has its pull-up on as well
      pad_pullup[i] = pcaf_pick(pullup_override_enable[i], pullup_override_value[i], pullup_normal[i])
        & ~dir_eff[i];
      pad_input_enable[i] = pcaf_pick(input_enable_override_enable[i], input_enable_override_value[i], 1'b1);
    end
  end

  always_comb begin
    pad_slew_limit = '0;
    pad_slew_limit[BIT_SCL] = two_wire_enable;
    pad_slew_limit[BIT_SDA] = two_wire_enable;
  end

  // =====================================================================
  // input sampling
  // a disabled buffer reads low, so a floating analog level cannot toggle logic
  always_comb begin
    state_next = state_reg;
    state_next.pin_sample = pad_in & pad_input_enable;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg.pin_sample <= PIN_SAMPLE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // pin-change sources see the pin even while bit 6 is the reset input
  assign pin_change_source = state_reg.pin_sample;

  // =====================================================================
  // register read-back
  always_comb begin
    direction_read = portc_direction;
    output_latch_read = portc_output_latch;
    input_sample_read = state_reg.pin_sample;
    if (reset_mode) begin
      direction_read[BIT_RESET] = 1'b0;
      output_latch_read[BIT_RESET] = 1'b0;
      input_sample_read[BIT_RESET] = 1'b0;
    end
  end

  // =====================================================================
  // reset pin
  // released level when the pin is ordinary I/O
  assign ext_reset_n = reset_mode ? pad_in[BIT_RESET] : 1'b1;

  // =====================================================================
  // two-wire spike filter
  // idle-high lines feed the filter while the port owns the pins
  pcaf_filt_if filt ();

  // one process drives both lanes, so the lane vector has a single writer
  always_comb begin
    filt.raw = {FILT_LINES{FILT_LINE_RST}};
    if (two_wire_enable) begin
      filt.raw[FILT_SCL] = pad_in[BIT_SCL];
      filt.raw[FILT_SDA] = pad_in[BIT_SDA];
    end
  end

  pcaf_spike_filter #(
    .MIN_CYCLES(SPIKE_CYCLES_P)
  ) u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .lines(filt.flt)
  );

  assign scl_in = filt.clean[FILT_SCL];
  assign sda_in = filt.clean[FILT_SDA];

endmodule

// File: common/pcaf_pkg.sv
// constants shared by the port c alternate function override block
package pcaf_pkg;

  // =====================================================================
  // port layout
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned NUM_CONV_CH = 6;
  localparam int unsigned BIT_SDA = 4;
  localparam int unsigned BIT_SCL = 5;
  localparam int unsigned BIT_RESET = 6;
  localparam int unsigned BIT_TOP = 7;
  localparam int unsigned PCINT_BASE = 8;

  // =====================================================================
  // spike filter timing
  localparam int unsigned SPIKE_MIN_PS = 50000;
  localparam int unsigned CLK_PERIOD_PS = 20000;
  // least time, so round up
  localparam int unsigned SPIKE_CYCLES = (SPIKE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // =====================================================================
  // filter lanes and reset values
  localparam int unsigned FILT_LINES = 2;
  localparam int unsigned FILT_SDA = 0;
  localparam int unsigned FILT_SCL = 1;
  localparam logic [PORT_WIDTH-1:0] PIN_SAMPLE_RST = 8'h00;
  localparam logic FILT_LINE_RST = 1'b1;

endpackage

// File: common/pcaf_filt_if.sv
// interface between the override logic and its two-wire spike filter
`timescale 1ns/1ps
interface pcaf_filt_if;
  import pcaf_pkg::*;

  logic [FILT_LINES-1:0] raw;
  logic [FILT_LINES-1:0] clean;

  modport src (output raw, input clean);
  modport flt (input raw, output clean);
endinterface

// File: rtl/pcaf_spike_filter.sv
// spike filter for the two-wire clock and data inputs
`timescale 1ns/1ps
module pcaf_spike_filter
  import pcaf_pkg::*;
#(
  parameter int unsigned MIN_CYCLES = SPIKE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // filtered lines
  pcaf_filt_if.flt lines
);

  localparam int unsigned CW = $clog2(MIN_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(MIN_CYCLES - 1);

  typedef struct packed {
    logic [FILT_LINES-1:0][CW-1:0] cnt;
    logic [FILT_LINES-1:0] clean;
  } pcaf_flt_state_s;

  pcaf_flt_state_s state_reg;
  pcaf_flt_state_s state_next;

  // =====================================================================
  // filter
  // a level must hold for the full count before it passes, so shorter
  // pulses vanish; the cost is a fixed delay of that many cycles
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < FILT_LINES; i++) begin
      if (lines.raw[i] == state_reg.clean[i]) begin
        state_next.cnt[i] = '0;
      end else if (state_reg.cnt[i] == LAST) begin
        state_next.cnt[i] = '0;
        state_next.clean[i] = lines.raw[i];
      end else begin
        state_next.cnt[i] = state_reg.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg.cnt <= '0;
      state_reg.clean <= {FILT_LINES{FILT_LINE_RST}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign lines.clean = state_reg.clean;

endmodule

// File: verification/pcaf_pad_model.sv
// pad and external bus model outside port c
`timescale 1ns/1ps
module pcaf_pad_model (
  // clock
  input wire logic clk,
  // from the block
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  // far side drive
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // to the block
  output logic [7:0] pad_in
);
  // floating pads without pull-up wander, so no stale level survives
  logic [7:0] drift_reg = 8'h55;
  always_ff @(posedge clk) drift_reg <= ~drift_reg;
  // a driving pad wins; a released pad shows the far side, else pull-up or drift
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | (~ext_en & (pad_pullup | drift_reg))));
endmodule

// File: verification/pcaf_top_props.sv
// assertion checker for the port c override block
`timescale 1ns/1ps
module pcaf_props (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // configuration
  input wire logic [7:0] portc_direction,
  input wire logic [7:0] portc_output_latch,
  input wire logic global_pullup_disable,
  input wire logic reset_pin_disable_fuse,
  input wire logic two_wire_enable,
  input wire logic pin_change_group1_enable,
  input wire logic [7:0] pin_change_mask,
  input wire logic [5:0] conv_digital_input_disable,
  input wire logic scl_out,
  input wire logic sda_out,
  // block outputs
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ext_reset_n,
  input wire logic [15:8] pin_change_source,
  input wire logic [7:0] direction_read,
  input wire logic [7:0] output_latch_read,
  // pads
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] pad_slew_limit,
  input wire logic [7:0] pad_input_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] seen;
  logic [5:0] armed;
  assign seen = pad_in & pad_input_enable;
  assign armed = pin_change_mask[5:0] & {6{pin_change_group1_enable}};
  // ==========
  // properties
  property p_scl; two_wire_enable |-> !pad_out[5] && pad_oe[5] == scl_out; endproperty
  a_scl: assert property (p_scl) else $error("scl pad not open drain");
  property p_sda; two_wire_enable |-> !pad_out[4] && pad_oe[4] == sda_out; endproperty
  a_sda: assert property (p_sda) else $error("sda pad not open drain");
  property p_filt;
    $changed(scl_in) && $past(two_wire_enable) && $past(two_wire_enable, 2) && $past(two_wire_enable, 3)
      && !$past(sys_rst) && !$past(sys_rst, 3) |-> $past(pad_in[5]) == scl_in && $past(pad_in[5], 3) == scl_in;
  endproperty
  a_filt: assert property (p_filt) else $error("clock line change too early");
  property p_filt_sda;
    $changed(sda_in) && $past(two_wire_enable) && $past(two_wire_enable, 2) && $past(two_wire_enable, 3)
      && !$past(sys_rst) && !$past(sys_rst, 3) |-> $past(pad_in[4]) == sda_in && $past(pad_in[4], 3) == sda_in;
  endproperty
  a_filt_sda: assert property (p_filt_sda) else $error("data line change too early");
  property p_twpu;
    two_wire_enable |-> pad_pullup[5:4] == (portc_output_latch[5:4] & ~{scl_out, sda_out} & {2{!global_pullup_disable}})
      && pad_slew_limit[5:4] == 2'b11;
  endproperty
  a_twpu: assert property (p_twpu) else $error("two-wire pull-up or slew wrong");
  property p_rst; !reset_pin_disable_fuse |-> ext_reset_n == pad_in[6] && !pad_oe[6] && pad_pullup[6]; endproperty
  a_rst: assert property (p_rst) else $error("reset pin not routed");
  property p_io; reset_pin_disable_fuse |-> ext_reset_n && pad_oe[6] == portc_direction[6]; endproperty
  a_io: assert property (p_io) else $error("bit 6 not plain io");
  property p_rd; !reset_pin_disable_fuse |-> !direction_read[6] && !output_latch_read[6]; endproperty
  a_rd: assert property (p_rd) else $error("bit 6 read-back not zero");
  property p_pc; !$past(sys_rst) |-> pin_change_source == $past(seen); endproperty
  a_pc: assert property (p_pc) else $error("pin change source wrong");
  property p_ie; pad_input_enable == {2'b11, ~(conv_digital_input_disable & ~armed)}; endproperty
  a_ie: assert property (p_ie) else $error("input enable wrong");
  property p_own; !two_wire_enable |-> pad_oe[5:4] == portc_direction[5:4] && pad_slew_limit == 8'h00; endproperty
  a_own: assert property (p_own) else $error("override without owner");
  property p_pud; global_pullup_disable |-> (pad_pullup & {1'b1, reset_pin_disable_fuse, 6'h3f}) == 8'h00; endproperty
  a_pud: assert property (p_pud) else $error("pull-up not disabled");
endmodule
bind pcaf_top pcaf_props pcaf_props_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .portc_direction(portc_direction),
  .portc_output_latch(portc_output_latch),
  .global_pullup_disable(global_pullup_disable),
  .reset_pin_disable_fuse(reset_pin_disable_fuse),
  .two_wire_enable(two_wire_enable),
  .pin_change_group1_enable(pin_change_group1_enable),
  .pin_change_mask(pin_change_mask),
  .conv_digital_input_disable(conv_digital_input_disable),
  .scl_out(scl_out),
  .sda_out(sda_out),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .ext_reset_n(ext_reset_n),
  .pin_change_source(pin_change_source),
  .direction_read(direction_read),
  .output_latch_read(output_latch_read),
  .pad_in(pad_in),
  .pad_out(pad_out),
  .pad_oe(pad_oe),
  .pad_pullup(pad_pullup),
  .pad_slew_limit(pad_slew_limit),
  .pad_input_enable(pad_input_enable)
);

// File: verification/pcaf_tb_top.sv
// self-checking bench for the port c override block
`timescale 1ns/1ps
module pcaf_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic global_pullup_disable = 1'b0, reset_pin_disable_fuse = 1'b1, two_wire_enable = 1'b0;
  logic pin_change_group1_enable = 1'b0, scl_out = 1'b0, sda_out = 1'b0;
  logic [7:0] portc_direction = 8'h00, portc_output_latch = 8'h00, pin_change_mask = 8'h00;
  logic [7:0] ext_val = 8'hff, ext_en = 8'hff;
  logic [5:0] conv_digital_input_disable = 6'h00;
  logic scl_in, sda_in, ext_reset_n;
  logic [15:8] pin_change_source;
  logic [7:0] direction_read, output_latch_read, input_sample_read, pad_in, pad_out, pad_oe;
  logic [7:0] pad_pullup, pad_slew_limit, pad_input_enable, smp, eoe, m6;
  logic [31:0] r;
  int miscompares = 0, n_checks = 0;

  pcaf_top pcaf_top_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .portc_direction(portc_direction),
    .portc_output_latch(portc_output_latch),
    .global_pullup_disable(global_pullup_disable),
    .reset_pin_disable_fuse(reset_pin_disable_fuse),
    .two_wire_enable(two_wire_enable),
    .pin_change_group1_enable(pin_change_group1_enable),
    .pin_change_mask(pin_change_mask),
    .conv_digital_input_disable(conv_digital_input_disable),
    .scl_out(scl_out),
    .sda_out(sda_out),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ext_reset_n(ext_reset_n),
    .pin_change_source(pin_change_source),
    .direction_read(direction_read),
    .output_latch_read(output_latch_read),
    .input_sample_read(input_sample_read),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pullup(pad_pullup),
    .pad_slew_limit(pad_slew_limit),
    .pad_input_enable(pad_input_enable)
  );
  pcaf_pad_model pcaf_pad_model_i (
    .clk(clk),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pullup(pad_pullup),
    .ext_val(ext_val),
    .ext_en(ext_en),
    .pad_in(pad_in)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  // ==========
  // expectations
  function automatic logic [7:0] f_ie();
    logic [5:0] armed;
    armed = pin_change_mask[5:0] & {6{pin_change_group1_enable}};
    return {2'b11, ~(conv_digital_input_disable & ~armed)};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pads();
    eoe = portc_direction;
    if (two_wire_enable) eoe[5:4] = {scl_out, sda_out};
    if (!reset_pin_disable_fuse) eoe[6] = 1'b0;
    m6 = reset_pin_disable_fuse ? 8'hff : 8'hbf;
    chk("oe", eoe, pad_oe);
    chk("out", eoe & portc_output_latch & {2'b11, ~{2{two_wire_enable}}, 4'hf}, pad_out & eoe);
    chk("pullup", (~eoe & portc_output_latch & {8{~global_pullup_disable}} & m6) | ~m6, pad_pullup);
    chk("slew", {2'b00, {2{two_wire_enable}}, 4'h0}, pad_slew_limit);
    chk("ie", f_ie(), pad_input_enable);
    chk("dir", portc_direction & m6, direction_read);
    chk("latch", portc_output_latch & m6, output_latch_read);
    chk("rst", {7'h0, reset_pin_disable_fuse | pad_in[6]}, {7'h0, ext_reset_n});
    chk("pcint", smp, pin_change_source);
    chk("sample", smp & m6, input_sample_read);
    smp = pad_in & f_ie();
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========
  // tests
  initial begin
    r = $urandom(32'h5f817a60);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // fuse held per block so a sample never straddles a mode change
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      reset_pin_disable_fuse <= f[0];
      @(negedge clk);
      smp = pad_in & f_ie();
      repeat (150) begin
        @(posedge clk);
        r = $urandom;
        {portc_direction, portc_output_latch, pin_change_mask, ext_val} <= r;
        r = $urandom;
        {conv_digital_input_disable, global_pullup_disable, two_wire_enable, pin_change_group1_enable,
          scl_out, sda_out} <= r[10:0];
        ext_en <= r[18:11] | r[26:19];
        @(negedge clk);
        chk_pads();
      end
    end
    @(posedge clk);
    {two_wire_enable, scl_out, sda_out, ext_val, ext_en} <= {3'b100, 16'hffff};
    repeat (4) @(posedge clk);
    for (int b = 4; b < 6; b++) begin
      for (int w = 2; w < 4; w++) begin
        ext_val <= ~(8'h01 << b);
        repeat (w) @(posedge clk);
        ext_val <= 8'hff;
        @(negedge clk);
        chk("filter", {7'h0, w == 2}, {7'h0, b == 5 ? scl_in : sda_in});
        repeat (4) @(posedge clk);
      end
    end
    {two_wire_enable, global_pullup_disable, portc_direction, portc_output_latch} <= {2'b01, 16'h00ff};
    @(negedge clk);
    chk("pud", 8'h00, pad_pullup);
    complete_run();
  end

  initial begin
    #40us;
    miscompares++;
    complete_run();
  end
endmodule
